// file: hdl/ppo_consts.vh
// Constants for the port pin override and sleep clamp block.
// Assumes a 32-bit AHB-Lite register bus and one 8-pin port.
// Summary of operation
// R1 - Input gate can force digital input low
// R2 - Clamp only in deep sleep modes
// R3 - Enabled external interrupt bypasses the clamp
// R4 - Disabled external interrupt pin is clamped normally
// R5 - Clamp release counts as an edge
// R6 - Software gives unused pins defined levels
// R7 - Pull-up forced off during reset
// R8 - Default pull-up when direction/level/kill is 010
// R9 - Pull-up override value wins when enabled
// R10 - Driver enable from direction bit or override
// R11 - Driver override value switches driver directly
// R12 - Driven level from level bit or override
// R13 - Level override value wins when enabled
// R14 - Input enable from sleep state or override
// R15 - Input override value wins over sleep state
// R16 - Alternate functions get unsynchronised Schmitt output
// R17 - Analog path tied straight to pad
// R18 - Peripherals generate their own override pairs
// R19 - Strobes per port, clamp and kill shared
// R20 - Direction one means output, zero input
// R21 - Pins tri-state immediately under reset
// R22 - Readback via high latch then rising register
// R23 - Override muxes purely combinational
`ifndef PPO_CONSTS_VH
`define PPO_CONSTS_VH

// Port geometry
`define PPO_PIN_COUNT        8
// Register byte offsets
`define PPO_OFS_DIRECTION    8'h00
`define PPO_OFS_LEVEL        8'h04
`define PPO_OFS_SAMPLED      8'h08
`define PPO_OFS_CONTROL      8'h0C
`define PPO_OFS_EXT_ENABLE   8'h10
`define PPO_OFS_EXT_SENSE    8'h14
`define PPO_OFS_EXT_FLAG     8'h18
// Control register fields
`define PPO_CTRL_KILL_BIT    0
`define PPO_CTRL_MODE_LSB    4
`define PPO_CTRL_MODE_MSB    6
// Reset values
`define PPO_RST_BYTE         8'h00
`define PPO_RST_SENSE        16'h0000
`define PPO_RST_MODE         3'h0
// Sleep mode codes
`define PPO_MODE_IDLE        3'h0
`define PPO_MODE_ADC_NR      3'h1
`define PPO_MODE_POWER_DOWN  3'h2
`define PPO_MODE_POWER_SAVE  3'h3
`define PPO_MODE_STANDBY     3'h6
`define PPO_MODE_EXT_STANDBY 3'h7
// External interrupt sense codes
`define PPO_SENSE_LEVEL      2'h0
`define PPO_SENSE_ANY        2'h1
`define PPO_SENSE_FALL       2'h2
`define PPO_SENSE_RISE       2'h3
// AHB transfer type bit that marks an active transfer
`define PPO_HTRANS_ACTIVE    1

`endif

// file: hdl/ppo_pin_sync.v
// Readback synchroniser for the port's sampled pin values.
// Assumes the inputs are the gated Schmitt outputs of the pins.
`timescale 1ns/1ps
`include "ppo_consts.vh"

module ppo_pin_sync (
   // Clock, reset, enable
   input  wire                       clk_sys,
   input  wire                       reset_n,
   input  wire                       clkEn,
   // Gated pin values in
   input  wire [`PPO_PIN_COUNT-1:0]  schmittIn,
   // Synchronised values out
   output reg  [`PPO_PIN_COUNT-1:0]  syncOut
);

   reg [`PPO_PIN_COUNT-1:0] latchStage;

   // R22 high-phase latch stage
   // Value seen while the clock is high is held at the falling edge
   always @(negedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         latchStage <= `PPO_RST_BYTE;
      end else if (clkEn) begin
         latchStage <= schmittIn;
      end
   end

   // R22 rising-edge register
   // Only this register reads the latch stage
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         syncOut <= `PPO_RST_BYTE;
      end else if (clkEn) begin
         syncOut <= latchStage;
      end
   end

endmodule // ppo_pin_sync

// file: hdl/ppo_port.v
// One general-purpose port: register file, override muxes, sleep clamp
// and external interrupt edge flags.
// Assumes AHB-Lite single word transfers, pad inputs synchronous to
// clk_sys, and override pairs driven by the owning peripherals.
//
// Implementation choices: the register offsets and the AHB-Lite slave port.
`timescale 1ns/1ps
`include "ppo_consts.vh"

module ppo_port (
   // Clock, reset, enable
   input  wire                       clk_sys,
   input  wire                       reset_n,
   input  wire                       clkEn,
   // AHB-Lite slave
   input  wire                       hsel,
   input  wire [7:0]                 haddr,
   input  wire [1:0]                 htrans,
   input  wire                       hwrite,
   input  wire [2:0]                 hsize,
   input  wire [31:0]                hwdata,
   input  wire                       hready,
   output reg  [31:0]                hrdata,
   output wire                       hreadyout,
   output wire                       hresp,
   // Processor sleep state
   input  wire                       cpuSleeping,
   // Pads
   input  wire [`PPO_PIN_COUNT-1:0]  padIn,
   output wire [`PPO_PIN_COUNT-1:0]  padOut,
   output wire [`PPO_PIN_COUNT-1:0]  padOe,
   output wire [`PPO_PIN_COUNT-1:0]  pullupOn,
   // Alternate function overrides
   input  wire [`PPO_PIN_COUNT-1:0]  pullup_ovr_en,
   input  wire [`PPO_PIN_COUNT-1:0]  pullup_ovr_val,
   input  wire [`PPO_PIN_COUNT-1:0]  drive_ovr_en,
   input  wire [`PPO_PIN_COUNT-1:0]  drive_ovr_val,
   input  wire [`PPO_PIN_COUNT-1:0]  level_ovr_en,
   input  wire [`PPO_PIN_COUNT-1:0]  level_ovr_val,
   input  wire [`PPO_PIN_COUNT-1:0]  input_gate_ovr_en,
   input  wire [`PPO_PIN_COUNT-1:0]  input_gate_ovr_val,
   // Alternate function inputs
   output wire [`PPO_PIN_COUNT-1:0]  alt_fn_schmitt_input,
   output wire [`PPO_PIN_COUNT-1:0]  analog_pad_line,
   // Shared control observed by other ports
   output wire                       sleepClamp,
   output wire                       global_pullup_kill
);

   // Software-visible state
   reg  [`PPO_PIN_COUNT-1:0]   pin_direction_bit;
   reg  [`PPO_PIN_COUNT-1:0]   pin_output_level_bit;
   reg                         pullupKill;
   reg  [2:0]                  sleepMode;
   reg  [`PPO_PIN_COUNT-1:0]   extIrqEnable;
   reg  [2*`PPO_PIN_COUNT-1:0] extIrqSense;
   reg  [`PPO_PIN_COUNT-1:0]   extIrqFlag;
   reg  [`PPO_PIN_COUNT-1:0]   prevSampled;
   wire [`PPO_PIN_COUNT-1:0]   pin_sampled_value;

   // Bus data phase state
   reg                         dataPhaseWrite;
   reg  [7:0]                  dataPhaseAddr;

   // Per-pin combinational results
   wire [`PPO_PIN_COUNT-1:0]   defaultPullup;
   wire [`PPO_PIN_COUNT-1:0]   driveEn;
   wire [`PPO_PIN_COUNT-1:0]   driveLevel;
   wire [`PPO_PIN_COUNT-1:0]   sleepGate;
   wire [`PPO_PIN_COUNT-1:0]   inputGate;
   wire [`PPO_PIN_COUNT-1:0]   pullupSel;
   wire [`PPO_PIN_COUNT-1:0]   edgeSeen;
   wire                        deepMode;

   // Bus decode
   wire                        accessTaken;
   wire                        port_direction_write_strobe;
   wire                        port_level_write_strobe;
   wire                        controlWrite;
   wire                        extEnableWrite;
   wire                        extSenseWrite;
   wire                        extFlagWrite;
   reg  [31:0]                 next_hrdata;

   // Zero wait state slave, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // Address phase accepted on an active selected transfer
   assign accessTaken = hsel & hready & htrans[`PPO_HTRANS_ACTIVE];

   // R19 write strobes shared by all pins of the port
   assign port_direction_write_strobe = dataPhaseWrite &
                                        (dataPhaseAddr == `PPO_OFS_DIRECTION);
   assign port_level_write_strobe     = dataPhaseWrite &
                                        (dataPhaseAddr == `PPO_OFS_LEVEL);
   assign controlWrite                = dataPhaseWrite &
                                        (dataPhaseAddr == `PPO_OFS_CONTROL);
   assign extEnableWrite              = dataPhaseWrite &
                                        (dataPhaseAddr == `PPO_OFS_EXT_ENABLE);
   assign extSenseWrite               = dataPhaseWrite &
                                        (dataPhaseAddr == `PPO_OFS_EXT_SENSE);
   assign extFlagWrite                = dataPhaseWrite &
                                        (dataPhaseAddr == `PPO_OFS_EXT_FLAG);

   // Capture the address phase for the following data phase
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         dataPhaseWrite <= 1'b0;
         dataPhaseAddr  <= 8'h00;
      end else if (clkEn) begin
         dataPhaseWrite <= accessTaken & hwrite;
         dataPhaseAddr  <= haddr;
      end
   end

   // Read mux, evaluated in the address phase
   always @* begin
      next_hrdata = 32'h00000000;
      case (haddr)
         `PPO_OFS_DIRECTION:  next_hrdata[`PPO_PIN_COUNT-1:0] = pin_direction_bit;
         `PPO_OFS_LEVEL:      next_hrdata[`PPO_PIN_COUNT-1:0] = pin_output_level_bit;
         `PPO_OFS_SAMPLED:    next_hrdata[`PPO_PIN_COUNT-1:0] = pin_sampled_value;
         `PPO_OFS_CONTROL: begin
            next_hrdata[`PPO_CTRL_KILL_BIT] = pullupKill;
            next_hrdata[`PPO_CTRL_MODE_MSB:`PPO_CTRL_MODE_LSB] = sleepMode;
         end
         `PPO_OFS_EXT_ENABLE: next_hrdata[`PPO_PIN_COUNT-1:0] = extIrqEnable;
         `PPO_OFS_EXT_SENSE:  next_hrdata[2*`PPO_PIN_COUNT-1:0] = extIrqSense;
         `PPO_OFS_EXT_FLAG:   next_hrdata[`PPO_PIN_COUNT-1:0] = extIrqFlag;
         default:             next_hrdata = 32'h00000000;
      endcase
   end

   // Read data register, stands through the data phase
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         hrdata <= 32'h00000000;
      end else if (clkEn) begin
         if (accessTaken & ~hwrite) begin
            hrdata <= next_hrdata;
         end
      end
   end

   // R20 direction and level registers
   // R7 reset clears level bits so no pull-up survives reset
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pin_direction_bit    <= `PPO_RST_BYTE;
         pin_output_level_bit <= `PPO_RST_BYTE;
      end else if (clkEn) begin
         if (port_direction_write_strobe) begin
            pin_direction_bit <= hwdata[`PPO_PIN_COUNT-1:0];
         end
         if (port_level_write_strobe) begin
            pin_output_level_bit <= hwdata[`PPO_PIN_COUNT-1:0];
         end
      end
   end

   // Control and external interrupt configuration
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pullupKill   <= 1'b0;
         sleepMode    <= `PPO_RST_MODE;
         extIrqEnable <= `PPO_RST_BYTE;
         extIrqSense  <= `PPO_RST_SENSE;
      end else if (clkEn) begin
         if (controlWrite) begin
            pullupKill <= hwdata[`PPO_CTRL_KILL_BIT];
            sleepMode  <= hwdata[`PPO_CTRL_MODE_MSB:`PPO_CTRL_MODE_LSB];
         end
         if (extEnableWrite) begin
            extIrqEnable <= hwdata[`PPO_PIN_COUNT-1:0];
         end
         if (extSenseWrite) begin
            extIrqSense <= hwdata[2*`PPO_PIN_COUNT-1:0];
         end
      end
   end

   // R2 deep sleep modes that clamp inputs
   assign deepMode = (sleepMode == `PPO_MODE_POWER_DOWN) |
                     (sleepMode == `PPO_MODE_POWER_SAVE) |
                     (sleepMode == `PPO_MODE_STANDBY)    |
                     (sleepMode == `PPO_MODE_EXT_STANDBY);
   // R2 never clamped in reset or while running
   // R19 clamp and pull-up kill shared across ports
   assign sleepClamp         = reset_n & cpuSleeping & deepMode;
   assign global_pullup_kill = pullupKill;

   // Per-pin override logic
   // R23 combinational override muxes
   genvar i;
   generate
      for (i = 0; i < `PPO_PIN_COUNT; i = i + 1) begin : g_pin
         // R8 default pull-up when {dir, level, kill} = 010
         assign defaultPullup[i] = ~pin_direction_bit[i] & pin_output_level_bit[i] &
                                   ~pullupKill;
         // R9 override value decides when enabled
         assign pullupSel[i]     = pullup_ovr_en[i] ? pullup_ovr_val[i]
                                                    : defaultPullup[i];
         // R7 pull-up off during reset
         assign pullupOn[i]      = reset_n & pullupSel[i];

         // R10 driver enable source select
         // R11 override value switches driver
         assign driveEn[i]       = drive_ovr_en[i] ? drive_ovr_val[i]
                                                   : pin_direction_bit[i];
         // R21 tri-state as soon as reset asserts
         assign padOe[i]         = reset_n & driveEn[i];

         // R12 driven level source select
         // R13 level override wins
         assign driveLevel[i]    = level_ovr_en[i] ? level_ovr_val[i]
                                                   : pin_output_level_bit[i];
         assign padOut[i]        = driveLevel[i];

         // R3 enabled interrupt bypasses the clamp
         // R4 disabled interrupt pins stay clamped
         assign sleepGate[i]     = ~sleepClamp | extIrqEnable[i];
         // R14 input enable source select
         // R15 override value wins over sleep
         assign inputGate[i]     = input_gate_ovr_en[i] ? input_gate_ovr_val[i]
                                                        : sleepGate[i];
         // R1 gate forces Schmitt input to ground
         // R16 alternate functions see it before synchronising
         assign alt_fn_schmitt_input[i] = padIn[i] & inputGate[i];

         // R17 analog line taken straight from the pad
         assign analog_pad_line[i] = padIn[i];

         // R5 clamp release seen as a change on the input
         assign edgeSeen[i] =
            ((extIrqSense[2*i+1:2*i] == `PPO_SENSE_ANY) &
             (pin_sampled_value[i] ^ prevSampled[i])) |
            ((extIrqSense[2*i+1:2*i] == `PPO_SENSE_FALL) &
             (~pin_sampled_value[i] & prevSampled[i])) |
            ((extIrqSense[2*i+1:2*i] == `PPO_SENSE_RISE) &
             (pin_sampled_value[i] & ~prevSampled[i]));
      end
   endgenerate

   // R22 readback synchroniser
   ppo_pin_sync u_sync (
      .clk_sys   (clk_sys),
      .reset_n   (reset_n),
      .clkEn     (clkEn),
      .schmittIn (alt_fn_schmitt_input),
      .syncOut   (pin_sampled_value)
   );

   // Edge flags: set whatever the enable, write one to clear, set wins
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         prevSampled <= `PPO_RST_BYTE;
         extIrqFlag  <= `PPO_RST_BYTE;
      end else if (clkEn) begin
         prevSampled <= pin_sampled_value;
         if (extFlagWrite) begin
            extIrqFlag <= (extIrqFlag & ~hwdata[`PPO_PIN_COUNT-1:0]) | edgeSeen;
         end else begin
            extIrqFlag <= extIrqFlag | edgeSeen;
         end
      end
   end

endmodule // ppo_port

// file: bench/ppo_port_monitor.sv
// Checker for the port pin block: override muxes, input clamp, reset.
// Assumes it is bound to ppo_port and sees only that module's ports.
`timescale 1ns/1ps
`include "ppo_consts.vh"

module ppo_port_monitor (
   // Clock, reset and sleep state
   input wire                      clk_sys,
   input wire                      reset_n,
   input wire                      cpuSleeping,
   // Pad side
   input wire [`PPO_PIN_COUNT-1:0] padIn,
   input wire [`PPO_PIN_COUNT-1:0] padOut,
   input wire [`PPO_PIN_COUNT-1:0] padOe,
   input wire [`PPO_PIN_COUNT-1:0] pullupOn,
   // Override pairs
   input wire [`PPO_PIN_COUNT-1:0] pullup_ovr_en,
   input wire [`PPO_PIN_COUNT-1:0] pullup_ovr_val,
   input wire [`PPO_PIN_COUNT-1:0] drive_ovr_en,
   input wire [`PPO_PIN_COUNT-1:0] drive_ovr_val,
   input wire [`PPO_PIN_COUNT-1:0] level_ovr_en,
   input wire [`PPO_PIN_COUNT-1:0] level_ovr_val,
   input wire [`PPO_PIN_COUNT-1:0] input_gate_ovr_en,
   input wire [`PPO_PIN_COUNT-1:0] input_gate_ovr_val,
   // Alternate function side and shared controls
   input wire [`PPO_PIN_COUNT-1:0] alt_fn_schmitt_input,
   input wire [`PPO_PIN_COUNT-1:0] analog_pad_line,
   input wire                      sleepClamp,
   input wire                      global_pullup_kill
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);

   // Awake pin with no input override
   sequence sAwake;
      !sleepClamp && input_gate_ovr_en == 8'h00;
   endsequence
   // Processor just woke up
   sequence sWake;
      $fell(cpuSleeping);
   endsequence

   AST_RST_PULL: assert property ($rose(reset_n) |-> $past(pullupOn) == 8'h00)
      else $error("pull-up on while reset held");
   AST_RST_DRIVE: assert property ($rose(reset_n) |-> $past(padOe) == 8'h00)
      else $error("driver on while reset held");
   AST_PULL_OVR: assert property ((pullupOn & pullup_ovr_en) == (pullup_ovr_val & pullup_ovr_en))
      else $error("pull-up ignores override value");
   AST_PULL_KILL: assert property (global_pullup_kill |-> (pullupOn & ~pullup_ovr_en) == 8'h00)
      else $error("pull-up on despite global kill");
   AST_DRIVE_OVR: assert property ((padOe & drive_ovr_en) == (drive_ovr_val & drive_ovr_en))
      else $error("driver ignores override value");
   AST_LEVEL_OVR: assert property ((padOut & level_ovr_en & padOe) == (level_ovr_val & level_ovr_en & padOe))
      else $error("driven level ignores override value");
   AST_GATE_OVR: assert property ((alt_fn_schmitt_input & input_gate_ovr_en) == (padIn & input_gate_ovr_val & input_gate_ovr_en))
      else $error("input gate ignores override value");
   AST_GATE_LOW: assert property ((alt_fn_schmitt_input & ~padIn) == 8'h00)
      else $error("gated input high while pad low");
   AST_AWAKE_INPUT: assert property (sAwake |-> alt_fn_schmitt_input == padIn)
      else $error("input gated while awake");
   AST_CLAMP_WAKE: assert property (sWake |-> !sleepClamp ##1 !sleepClamp)
      else $error("clamp held after wake-up");
   AST_ANALOG: assert property (analog_pad_line == padIn)
      else $error("analog line differs from pad");
endmodule // ppo_port_monitor

bind ppo_port ppo_port_monitor ppo_port_monitor_i (
   .clk_sys(clk_sys), .reset_n(reset_n), .cpuSleeping(cpuSleeping), .padIn(padIn),
   .padOut(padOut), .padOe(padOe), .pullupOn(pullupOn), .pullup_ovr_en(pullup_ovr_en),
   .pullup_ovr_val(pullup_ovr_val), .drive_ovr_en(drive_ovr_en),
   .drive_ovr_val(drive_ovr_val), .level_ovr_en(level_ovr_en),
   .level_ovr_val(level_ovr_val), .input_gate_ovr_en(input_gate_ovr_en),
   .input_gate_ovr_val(input_gate_ovr_val), .alt_fn_schmitt_input(alt_fn_schmitt_input),
   .analog_pad_line(analog_pad_line), .sleepClamp(sleepClamp),
   .global_pullup_kill(global_pullup_kill)
);

// file: bench/ppo_pad_model.sv
// Pads and alternate-function peripherals facing the port.
// Assumes an outside source always drives pins the port leaves undriven.
`timescale 1ns/1ps

module ppo_pad_model (
   // Scene choice and outside pad levels
   input  wire [1:0] scene,
   input  wire [7:0] extLvl,
   // Port driver
   input  wire [7:0] padOut,
   input  wire [7:0] padOe,
   // Pad level and override pair
   output wire [7:0] padIn,
   output reg  [7:0] ovrEn,
   output reg  [7:0] ovrVal
);
   // Pad follows the port driver, else the outside source
   // undriven pins kept at defined level
   assign padIn = (padOe & padOut) | (~padOe & extLvl);
   always @* begin
      case (scene)
         2'h1: {ovrEn, ovrVal} = 16'hF0A5;
         2'h2: {ovrEn, ovrVal} = 16'hFF0F;
         2'h3: {ovrEn, ovrVal} = 16'h0FFF;
         default: {ovrEn, ovrVal} = 16'h0000;
      endcase
   end
endmodule // ppo_pad_model

// file: bench/ppo_port_tb_top.sv
// Bench for the port pin block: registers, override muxes, sleep clamp.
// Assumes a zero-wait AHB-Lite slave and the pad model alongside.
`timescale 1ns/1ps

module ppo_port_tb_top;
   reg         clk_sys     = 1'b0;
   reg         reset_n     = 1'b0;
   reg         cpuSleeping = 1'b0;
   reg  [7:0]  haddr       = 8'h00;
   reg  [1:0]  htrans      = 2'h0;
   reg         hwrite      = 1'b0;
   reg  [31:0] hwdata      = 32'h0;
   reg  [1:0]  scene       = 2'h0;
   reg  [7:0]  extLvl      = 8'h5A;
   reg  [2:0]  mode;
   wire [31:0] hrdata;
   wire        hreadyout;
   wire [7:0]  padOut, padOe, pullupOn, padIn, ovrEn, ovrVal, altIn;
   wire        sleepClamp;
   wire        hresp;
   wire        killLine;
   wire [7:0]  anaLine;
   reg         clkEn       = 1'b1;
   integer     mismatches  = 0;
   integer     cmp_count   = 0;
   integer     i;

   ppo_port ppo_port_i (
      .clk_sys(clk_sys), .reset_n(reset_n), .clkEn(clkEn), .hsel(1'b1), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cpuSleeping(cpuSleeping),
      .padIn(padIn), .padOut(padOut), .padOe(padOe), .pullupOn(pullupOn),
      .pullup_ovr_en(ovrEn), .pullup_ovr_val(ovrVal), .drive_ovr_en(ovrEn),
      .drive_ovr_val(ovrVal), .level_ovr_en(ovrEn), .level_ovr_val(ovrVal),
      .input_gate_ovr_en(ovrEn), .input_gate_ovr_val(ovrVal),
      .alt_fn_schmitt_input(altIn), .analog_pad_line(anaLine), .sleepClamp(sleepClamp),
      .global_pullup_kill(killLine));

   ppo_pad_model ppo_pad_model_i (.scene(scene), .extLvl(extLvl), .padOut(padOut),
      .padOe(padOe), .padIn(padIn), .ovrEn(ovrEn), .ovrVal(ovrVal));

   // Free-running system clock
   always #5 clk_sys = ~clk_sys;

   // Compare and count
   task chk(input [31:0] seen, input [31:0] exp);
      begin
         cmp_count = cmp_count + 1;
         if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
         end
      end
   endtask

   // Bus cycle: address phase, then data phase, each held until hready
   task xfer(input [7:0] a, input w, input [31:0] d, input [31:0] m);
      begin
         @(posedge clk_sys);
         haddr <= a;
         hwrite <= w;
         htrans <= 2'h2;
         do @(posedge clk_sys); while (hreadyout !== 1'b1);
         htrans <= 2'h0;
         hwdata <= d;
         do @(posedge clk_sys); while (hreadyout !== 1'b1);
         if (!w) chk(hrdata & m, d & m);
      end
   endtask

   // Pin outputs against the mux rules
   task pins(input [7:0] dir, input [7:0] lvl, input kill, input [7:0] clampMask);
      reg [7:0] oe;
      begin
         oe = (ovrEn & ovrVal) | (~ovrEn & dir);
         chk(pullupOn, (ovrEn & ovrVal) | (~ovrEn & ~dir & lvl & {8{~kill}}));
         chk(padOe, oe);
         chk(padOut & oe, ((ovrEn & ovrVal) | (~ovrEn & lvl)) & oe);
         chk(altIn, padIn & ((ovrEn & ovrVal) | (~ovrEn & ~clampMask)));
         chk(anaLine, padIn);
         chk({hresp, killLine}, {1'b0, kill});
      end
   endtask

   // Closing verdict
   task end_sim;
      begin
         $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
         if (mismatches == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
         else
            $display("CHECKS NOT OK");
         $finish;
      end
   endtask

   // Watchdog far beyond the expected run of about 140 cycles
   initial begin
      #50000;
      mismatches = mismatches + 1;
      end_sim;
   end

   initial begin
      repeat (5) @(posedge clk_sys);
      reset_n <= 1'b1;
      #1 pins(8'h00, 8'h00, 1'b0, 8'h00);
      for (i = 0; i < 8; i = i + 1) begin
         xfer({i[5:0], 2'h0}, 1'b0, (i == 2) ? 32'h5A : 32'h0, 32'hFFFFFFFF);
      end
      xfer(8'h08, 1'b1, 32'hFF, 32'h0);
      extLvl <= 8'h3C;
      xfer(8'h08, 1'b0, 32'h3C, 32'hFFFFFFFF);
      xfer(8'h00, 1'b1, 32'h0F, 32'h0);
      xfer(8'h04, 1'b1, 32'h33, 32'h0);
      for (i = 0; i < 8; i = i + 1) begin
         scene <= i[1:0];
         xfer(8'h0C, 1'b1, {31'h0, i[2]}, 32'h0);
         #1 pins(8'h0F, 8'h33, i[2], 8'h00);
      end
      xfer(8'h0C, 1'b0, 32'h1, 32'hFFFFFFFF);
      scene <= 2'h0;
      xfer(8'h00, 1'b1, 32'h00, 32'h0);
      xfer(8'h10, 1'b1, 32'h01, 32'h0);
      cpuSleeping <= 1'b1;
      for (i = 0; i < 6; i = i + 1) begin
         mode = i[2:0] + ((i > 3) ? 3'h2 : 3'h0);
         xfer(8'h0C, 1'b1, {25'h0, mode, 4'h0}, 32'h0);
         #1 chk(sleepClamp, mode[1]);
         pins(8'h00, 8'h33, 1'b0, {{7{mode[1]}}, 1'b0});
      end
      cpuSleeping <= 1'b0;
      extLvl <= 8'hFF;
      xfer(8'h0C, 1'b1, 32'h20, 32'h0);
      xfer(8'h10, 1'b1, 32'h00, 32'h0);
      xfer(8'h14, 1'b1, 32'h6C, 32'h0);
      xfer(8'h18, 1'b1, 32'hFF, 32'h0);
      xfer(8'h18, 1'b0, 32'h0, 32'h0E);
      cpuSleeping <= 1'b1;
      repeat (3) @(posedge clk_sys);
      cpuSleeping <= 1'b0;
      repeat (4) @(posedge clk_sys);
      xfer(8'h18, 1'b0, 32'h0E, 32'h0E);
      xfer(8'h18, 1'b1, 32'h0E, 32'h0);
      xfer(8'h18, 1'b0, 32'h0, 32'h0E);
      // Clock enable low freezes the bus and the registers
      clkEn <= 1'b0;
      xfer(8'h04, 1'b1, 32'hFF, 32'h0);
      clkEn <= 1'b1;
      xfer(8'h04, 1'b0, 32'h33, 32'hFFFFFFFF);
      xfer(8'h04, 1'b1, 32'hFF, 32'h0);
      xfer(8'h00, 1'b1, 32'hF0, 32'h0);
      #1 pins(8'hF0, 8'hFF, 1'b0, 8'h00);
      @(posedge clk_sys);
      reset_n <= 1'b0;
      #1 chk(pullupOn, 8'h00);
      chk(padOe, 8'h00);
      repeat (2) @(posedge clk_sys);
      reset_n <= 1'b1;
      xfer(8'h04, 1'b0, 32'h0, 32'hFFFFFFFF);
      end_sim;
   end
endmodule // ppo_port_tb_top
